/* File: hw/sld_pkg.sv */
// Package with constants, states and carriers for the serial link deserializer controller
package sld_pkg;
	// Register byte offsets on the APB
	localparam logic [7:0] SLD_CTRL_OFS      = 8'h00;
	localparam logic [7:0] SLD_STATUS_OFS    = 8'h04;
	localparam logic [7:0] SLD_WORD_OFS      = 8'h08;
	localparam logic [7:0] SLD_IRQ_STAT_OFS  = 8'h0c;
	localparam logic [7:0] SLD_IRQ_CLR_OFS   = 8'h10;
	localparam logic [7:0] SLD_IRQ_EN_OFS    = 8'h14;
	localparam logic [7:0] SLD_ERR_CNT_OFS   = 8'h18;

	// Reset values
	localparam logic [0:0]  SLD_CTRL_RST     = 1'h1;
	localparam logic [2:0]  SLD_IRQ_EN_RST   = 3'h0;

	// Interrupt bit positions
	localparam int SLD_IRQ_LOCK_ACQ  = 0;
	localparam int SLD_IRQ_LOCK_LOST = 1;
	localparam int SLD_IRQ_FRAME_ERR = 2;

	// Frame layout: start bit, ten data bits, stop bit
	localparam logic [3:0] SLD_FRAME_LAST  = 4'hb;
	localparam logic [3:0] SLD_DATA_FIRST  = 4'h1;
	localparam logic [3:0] SLD_DATA_LAST   = 4'ha;
	localparam logic [3:0] SLD_RCLK_HIGH   = 4'h6;

	// Lock detector counts
	localparam logic [3:0] SLD_LOCK_FRAMES = 4'h8;
	localparam logic [2:0] SLD_LOSS_FRAMES = 3'h4;
	localparam logic [2:0] SLD_STALE_WORDS = 3'h5;

	// Reference clock supervision
	localparam real        SLD_SYS_CLK_MHZ   = 100.0;
	localparam real        SLD_REF_TIMEOUT_NS = 640.0;
	localparam logic [7:0] SLD_REF_TIMEOUT   = 8'(int'(SLD_REF_TIMEOUT_NS * SLD_SYS_CLK_MHZ / 1000.0));
	localparam logic [3:0] SLD_REF_EDGES     = 4'h4;

	// Index of each synchronised pin input
	localparam int SLD_IN_POS  = 0;
	localparam int SLD_IN_NEG  = 1;
	localparam int SLD_IN_EDGE = 2;
	localparam int SLD_IN_PWR  = 3;
	localparam int SLD_IN_OE   = 4;
	localparam int SLD_IN_REF  = 5;
	localparam int SLD_IN_W    = 6;

	// Receiver framing states
	typedef enum logic [0:0] {
		SLD_HUNT,
		SLD_TRACK
	} sld_state_t;

	// Parallel pin outputs that share one output enable
	typedef struct packed {
		logic [9:0] word;
		logic       rclk;
		logic       lock_n;
	} sld_pins_t;

	// Whole state of the controller
	typedef struct packed {
		logic [SLD_IN_W-1:0] s1;
		logic [SLD_IN_W-1:0] s2;
		sld_state_t          st;
		logic [3:0]          cnt;
		logic [9:0]          shift;
		logic                start_ok;
		logic                prev_bit;
		logic                locked;
		logic [3:0]          good_cnt;
		logic [2:0]          bad_cnt;
		logic [2:0]          stale;
		logic [9:0]          hold;
		logic [9:0]          word_out;
		logic                rclk;
		logic                ref_prev;
		logic [3:0]          ref_edges;
		logic [7:0]          ref_idle;
		logic                ctrl_en;
		logic [2:0]          irq_st;
		logic [2:0]          irq_en;
		logic [15:0]         err_cnt;
		logic [31:0]         prdata;
		logic                pslverr;
	} sld_regs_t;
endpackage

/* File: hw/sld_deser_ctl.sv */
// Receive controller: framing, lock detection, recovered clock and APB registers
`timescale 1ns/1ps
`default_nettype none

module sld_deser_ctl
	import sld_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	// Link and control pins
	input  wire logic        serial_in_pos,
	input  wire logic        serial_in_neg,
	input  wire logic        edge_select,
	input  wire logic        power_down_n,
	input  wire logic        output_enable,
	input  wire logic        reference_clock_in,
	// Parallel pins with shared output enable
	output sld_pins_t        pins_out,
	output logic             pins_oe,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Interrupt
	output logic             irq
);
	sld_regs_t r_reg;   // Registered state
	sld_regs_t r_next;  // Next state

	// Decode of a mapped register offset, used by the error logic
	function automatic logic sld_mapped(input logic [7:0] a);
		case (a)
			SLD_CTRL_OFS, SLD_STATUS_OFS, SLD_WORD_OFS, SLD_IRQ_STAT_OFS,
			SLD_IRQ_CLR_OFS, SLD_IRQ_EN_OFS, SLD_ERR_CNT_OFS: sld_mapped = 1'b1;
			default: sld_mapped = 1'b0;
		endcase
	endfunction

	logic       bit_in;     // Resolved differential bit
	logic       run;        // Receiver allowed to run
	logic       ref_ok;     // Reference clock is alive
	logic       frame_ok;   // Start and stop bits framed the word
	logic       wr_acc;     // APB write completes this edge
	logic [2:0] events;     // Interrupt events this cycle
	logic [9:0] word_new;   // Word with the last data bit shifted in

	// Next-state logic
	always_comb begin
		r_next = r_reg;
		events = 3'h0;
		frame_ok = 1'b0;
		// Two-stage synchronisers; only s2 is read below
		r_next.s1 = {reference_clock_in, output_enable, power_down_n, edge_select, serial_in_neg, serial_in_pos};
		r_next.s2 = r_reg.s1;
		bit_in = r_reg.s2[SLD_IN_POS] & ~r_reg.s2[SLD_IN_NEG];
		word_new = {bit_in, r_reg.shift[9:1]};

		// Reference supervision: the frequency reference must toggle
		r_next.ref_prev = r_reg.s2[SLD_IN_REF];
		if (r_reg.s2[SLD_IN_REF] != r_reg.ref_prev) begin
			r_next.ref_idle = 8'h0;
			if (r_reg.ref_edges != SLD_REF_EDGES)
				r_next.ref_edges = r_reg.ref_edges + 4'h1;
		end else if (r_reg.ref_idle == SLD_REF_TIMEOUT) begin
			r_next.ref_edges = 4'h0;
		end else begin
			r_next.ref_idle = r_reg.ref_idle + 8'h1;
		end
		ref_ok = (r_reg.ref_edges == SLD_REF_EDGES);

		run = r_reg.s2[SLD_IN_PWR] & ref_ok & r_reg.ctrl_en;
		r_next.prev_bit = bit_in;

		if (!run) begin
			// Stopped: drop lock so the indicator reads unlocked
			r_next.st = SLD_HUNT;
			r_next.cnt = 4'h0;
			r_next.locked = 1'b0;
			r_next.good_cnt = 4'h0;
			r_next.bad_cnt = 3'h0;
		end else begin
			case (r_reg.st)
				SLD_HUNT: begin
					// Embedded clock edge: stop low then start high
					if (!r_reg.prev_bit && bit_in) begin
						r_next.st = SLD_TRACK;
						r_next.cnt = SLD_DATA_FIRST;
						r_next.start_ok = 1'b1;
					end
				end
				SLD_TRACK: begin
					if (r_reg.cnt == 4'h0) begin
						r_next.start_ok = bit_in;
						r_next.cnt = SLD_DATA_FIRST;
					end else if (r_reg.cnt <= SLD_DATA_LAST) begin
						// LSB first into the shift register
						r_next.shift = word_new;
						r_next.cnt = r_reg.cnt + 4'h1;
					end else begin
						r_next.cnt = 4'h0;
						frame_ok = r_reg.start_ok & ~bit_in;
						if (frame_ok) begin
							r_next.hold = r_reg.shift;
						end else begin
							events[SLD_IRQ_FRAME_ERR] = 1'b1;
						end
						if (r_reg.locked) begin
							if (frame_ok) begin
								r_next.bad_cnt = 3'h0;
							end else if (r_reg.bad_cnt == SLD_LOSS_FRAMES - 3'h1) begin
								// Fourth bad frame in a row
								r_next.locked = 1'b0;
								r_next.stale = SLD_STALE_WORDS;
								r_next.bad_cnt = 3'h0;
								r_next.st = SLD_HUNT;
								events[SLD_IRQ_LOCK_LOST] = 1'b1;
							end else begin
								r_next.bad_cnt = r_reg.bad_cnt + 3'h1;
							end
						end else if (!frame_ok) begin
							// Misframed while acquiring: search again
							r_next.good_cnt = 4'h0;
							r_next.st = SLD_HUNT;
						end else if (r_reg.good_cnt == SLD_LOCK_FRAMES - 4'h1) begin
							r_next.locked = 1'b1;
							r_next.good_cnt = 4'h0;
							events[SLD_IRQ_LOCK_ACQ] = 1'b1;
						end else begin
							r_next.good_cnt = r_reg.good_cnt + 4'h1;
						end
					end
				end
				default: r_next.st = SLD_HUNT;
			endcase
		end

		// Word-rate clock: high for data counts 1 to 6, still while hunting or stopped.
		// Starting the high phase on the first data bit keeps the first frame after a
		// hunt as long as every later one, so only a stop during the high phase cuts a pulse short
		r_next.rclk = (r_next.st == SLD_TRACK) && (r_next.cnt >= SLD_DATA_FIRST)
			&& (r_next.cnt <= SLD_RCLK_HIGH);

		// Output word changes on the edge opposite to the strobe edge
		if (r_reg.s2[SLD_IN_EDGE]) begin
			if (r_reg.rclk && !r_next.rclk)
				r_next.word_out = r_reg.hold;
		end else begin
			if (!r_reg.rclk && r_next.rclk)
				r_next.word_out = r_reg.hold;
		end

		// Stale-word count is set on a loss and cleared once lock is regained
		if (events[SLD_IRQ_LOCK_ACQ])
			r_next.stale = 3'h0;

		// APB register writes
		wr_acc = psel & penable & pwrite;
		if (wr_acc && paddr == SLD_CTRL_OFS)
			r_next.ctrl_en = pwdata[0];
		if (wr_acc && paddr == SLD_IRQ_EN_OFS)
			r_next.irq_en = pwdata[2:0];
		// Set wins over a clear in the same cycle
		if (wr_acc && paddr == SLD_IRQ_CLR_OFS)
			r_next.irq_st = (r_reg.irq_st & ~pwdata[2:0]) | events;
		else
			r_next.irq_st = r_reg.irq_st | events;
		// Saturating frame error counter
		if (events[SLD_IRQ_FRAME_ERR] && r_reg.err_cnt != 16'hffff)
			r_next.err_cnt = r_reg.err_cnt + 16'h1;

		// Read data and error captured in the setup phase
		if (psel && !penable) begin
			r_next.pslverr = ~sld_mapped(paddr);
			case (paddr)
				SLD_CTRL_OFS:     r_next.prdata = {31'h0, r_reg.ctrl_en};
				SLD_STATUS_OFS:   r_next.prdata = {26'h0, r_reg.stale, pins_oe, ref_ok, r_reg.locked};
				SLD_WORD_OFS:     r_next.prdata = {22'h0, r_reg.hold};
				SLD_IRQ_STAT_OFS: r_next.prdata = {29'h0, r_reg.irq_st};
				SLD_IRQ_EN_OFS:   r_next.prdata = {29'h0, r_reg.irq_en};
				SLD_ERR_CNT_OFS:  r_next.prdata = {16'h0, r_reg.err_cnt};
				default:          r_next.prdata = 32'h0; // Clear register and unmapped read zero
			endcase
		end
	end

	// State register
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			r_reg <= '0;
			r_reg.st <= SLD_HUNT;
			r_reg.ctrl_en <= SLD_CTRL_RST;
			r_reg.irq_en <= SLD_IRQ_EN_RST;
		end else begin
			r_reg <= r_next;
		end
	end

	// Pin drivers; floated when powered down or disabled
	assign pins_oe = r_reg.s2[SLD_IN_PWR] & r_reg.s2[SLD_IN_OE];
	assign pins_out.word = r_reg.word_out;
	assign pins_out.rclk = r_reg.rclk;
	assign pins_out.lock_n = ~r_reg.locked;

	// APB answer without wait states
	assign prdata = r_reg.prdata;
	assign pslverr = r_reg.pslverr;
	assign pready = 1'b1;

	// Level interrupt from enabled sticky bits
	assign irq = |(r_reg.irq_st & r_reg.irq_en);
endmodule

`default_nettype wire

/* File: sim/sld_deser_ctl_assertions.sv */
// Port checker for the deserializer controller
`timescale 1ns/1ps
`default_nettype none
module sld_deser_chk
	import sld_pkg::*;
(
	// Clock and reset
	input wire logic      sys_clk,
	input wire logic      nrst,
	// Pins
	input wire logic      power_down_n,
	input wire logic      output_enable,
	input wire sld_pins_t pins_out,
	input wire logic      pins_oe,
	// Bus and interrupt
	input wire logic      psel,
	input wire logic      pready,
	input wire logic      irq
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	logic       r_q;  // Clock seen last cycle
	logic       lk_q; // Indicator seen last cycle
	logic [3:0] n_rc; // Clock rises since indicator changed
	// Saturating count, so a long locked run cannot wrap
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			r_q  <= 1'b0;
			lk_q <= 1'b1;
			n_rc <= 4'h0;
		end else begin
			r_q  <= pins_out.rclk;
			lk_q <= pins_out.lock_n;
			n_rc <= (pins_out.lock_n != lk_q) ? 4'h0 : n_rc + 4'(pins_out.rclk && !r_q && n_rc != 4'hf);
		end
	end
	property p_pd; !power_down_n [*5] |-> !pins_oe && pins_out.lock_n && !pins_out.rclk; endproperty
	a_pd: assert property (p_pd) else $error("pins live in power down");
	property p_oe; !output_enable [*4] |-> !pins_oe; endproperty
	a_oe: assert property (p_oe) else $error("pins live while disabled");
	property p_rclk; $rose(pins_out.rclk) |-> pins_out.rclk [*6] ##1 !pins_out.rclk [*5]; endproperty
	a_rclk: assert property (p_rclk) else $error("clock phase length");
	property p_word; !$stable(pins_out.word) |-> !$stable(pins_out.rclk); endproperty
	a_word: assert property (p_word) else $error("word moved off clock edge");
	property p_acq; $fell(pins_out.lock_n) |-> n_rc >= 4'h8; endproperty
	a_acq: assert property (p_acq) else $error("lock too early");
	property p_loss; $rose(pins_out.lock_n) && pins_oe |-> n_rc >= 4'h4; endproperty
	a_loss: assert property (p_loss) else $error("lock dropped too soon");
	property p_idle;
		pins_out.lock_n && !pins_out.rclk |=> !pins_out.lock_n || pins_out.rclk || $stable(pins_out.word);
	endproperty
	a_idle: assert property (p_idle) else $error("word moved while idle");
	property p_rdy; psel |-> pready; endproperty
	a_rdy: assert property (p_rdy) else $error("no ready");
	c_lock: cover property ($fell(pins_out.lock_n));
	c_loss: cover property ($rose(pins_out.lock_n) && pins_oe);
	c_irq: cover property ($rose(irq));
endmodule
bind sld_deser_ctl sld_deser_chk u_chk (.sys_clk(sys_clk), .nrst(nrst), .power_down_n(power_down_n),
	.output_enable(output_enable), .pins_out(pins_out), .pins_oe(pins_oe), .psel(psel), .pready(pready), .irq(irq));
`default_nettype wire

/* File: sim/sld_ser_model.sv */
// Behavioural remote serializer driving framed words
`timescale 1ns/1ps
`default_nettype none
module sld_ser_model
	import sld_pkg::*;
(
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       nrst,
	// Controls
	input  wire logic       align_request,
	input  wire logic       corrupt,
	input  wire logic [9:0] data_word,
	// Line and frame timing
	output logic            serial_in_pos,
	output logic            serial_in_neg,
	output logic            frame_start,
	output logic [9:0]      next_word
);
	logic [3:0]  slot;  // Bit slot in frame
	logic [9:0]  w;     // Word on the line
	logic [10:0] n_sym; // Patterns since request rose
	logic        req_q; // Request last cycle
	logic        bit_v; // Line level
	// Pattern while asked, and 1024 at least per request
	assign next_word = (align_request || n_sym != 11'h400) ? 10'h01f : data_word;
	assign frame_start = slot == SLD_FRAME_LAST;
	// Start high, data low bit first, stop low unless broken on purpose
	assign bit_v = (slot == 4'h0) ? 1'b1 : frame_start ? corrupt : w[slot - 4'h1];
	assign serial_in_pos = bit_v;
	assign serial_in_neg = ~bit_v;
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			slot  <= 4'h0;
			w     <= 10'h0;
			n_sym <= 11'h400;
			req_q <= 1'b0;
		end else begin
			req_q <= align_request;
			slot  <= frame_start ? 4'h0 : slot + 4'h1;
			if (align_request && !req_q)
				n_sym <= 11'h0;
			else if (frame_start && n_sym != 11'h400)
				n_sym <= n_sym + 11'h1;
			if (frame_start)
				w <= next_word;
		end
	end
endmodule
`default_nettype wire

/* File: sim/sld_deser_ctl_tb.sv */
// Self-checking bench for the deserializer controller
`timescale 1ns/1ps
`default_nettype none
module sld_deser_ctl_tb
	import sld_pkg::*;
;
	logic        sys_clk, nrst, es, pdn, oe, refc, psel, penable, pwrite, bad, chk, pe, r_q;
	logic        pready, pslverr, irq, pins_oe, sp, sn, fs;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd, seed;
	logic [9:0]  dw, nw;
	logic [29:0] hist; // Last three words sent, newest low
	sld_pins_t   pins;
	int          n_errors, n_tests, cyc;
	wire logic   lock_fb = !pins_oe || pins.lock_n; // Floated indicator pulled up
	sld_deser_ctl dut (.sys_clk(sys_clk), .nrst(nrst), .serial_in_pos(sp), .serial_in_neg(sn), .edge_select(es),
		.power_down_n(pdn), .output_enable(oe), .reference_clock_in(refc), .pins_out(pins), .pins_oe(pins_oe),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq));
	sld_ser_model u_ser (.sys_clk(sys_clk), .nrst(nrst), .align_request(lock_fb), .corrupt(bad),
		.data_word(dw), .serial_in_pos(sp), .serial_in_neg(sn), .frame_start(fs), .next_word(nw));
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] x;
		x = v ^ (v << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	// Strobe edge shows the word two frames back on rising, one on falling
	function automatic logic [9:0] exp_word(input logic e);
		return e ? hist[29:20] : hist[19:10];
	endfunction
	task automatic check(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value at %0t: %h not %h", $time, g, e);
		end
	endtask
	task automatic stop_test;
		if (n_errors == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Setup, then access held until ready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1) @(posedge sys_clk);
		rd = prdata;
		pe = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask
	// Reference, random words, strobe checks and the hang limit
	always @(posedge sys_clk) begin
		refc <= ~refc;
		cyc <= cyc + 1;
		r_q <= pins.rclk;
		if (fs) begin
			hist <= {hist[19:0], nw};
			seed <= xs(seed);
			dw <= seed[9:0];
		end
		if (chk && pins.rclk === es && r_q !== es)
			check({22'h0, pins.word}, {22'h0, exp_word(es)});
		if (cyc == 50000) begin
			n_errors++;
			stop_test();
		end
	end
	initial begin
		{nrst, psel, penable, pwrite, bad, chk, refc, r_q, pe} = '0;
		{es, pdn, oe} = 3'h7;
		{paddr, pwdata, rd, dw, hist} = '0;
		seed = 32'hdb35;
		{n_errors, n_tests, cyc} = '0;
		repeat (20) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		apb(1'b0, SLD_CTRL_OFS, 32'h0);
		check(rd, 32'h1);
		apb(1'b0, 8'h1c, 32'hffff_ffff);
		check({rd[30:0], pe}, 32'h1);
		apb(1'b1, SLD_IRQ_EN_OFS, 32'h1);
		check({31'h0, pins.lock_n}, 32'h1);
		while (pins.lock_n !== 1'b0) @(posedge sys_clk);
		repeat (2) @(posedge sys_clk);
		check({31'h0, irq}, 32'h1);
		apb(1'b1, SLD_IRQ_CLR_OFS, 32'h1);
		check({31'h0, irq}, 32'h0);
		repeat (12400) @(posedge sys_clk);
		for (int k = 0; k < 2; k++) begin
			es <= k[0];
			repeat (48) @(posedge sys_clk);
			chk <= 1'b1;
			repeat (600) @(posedge sys_clk);
			chk <= 1'b0;
		end
		bad <= 1'b1;
		repeat (36) @(posedge sys_clk);
		check({31'h0, pins.lock_n}, 32'h0);
		while (pins.lock_n !== 1'b1) @(posedge sys_clk);
		bad <= 1'b0;
		apb(1'b0, SLD_STATUS_OFS, 32'h0);
		check({28'h0, rd[5:3], irq}, 32'ha);
		apb(1'b0, SLD_IRQ_STAT_OFS, 32'h0);
		check({31'h0, rd[1]}, 32'h1);
		apb(1'b0, SLD_ERR_CNT_OFS, 32'h0);
		check({31'h0, |rd[15:0]}, 32'h1);
		while (pins.lock_n !== 1'b0) @(posedge sys_clk);
		while (!(r_q === 1'b1 && pins.rclk === 1'b0)) @(posedge sys_clk);
		pdn <= 1'b0;
		repeat (8) @(posedge sys_clk);
		check({30'h0, pins_oe, pins.lock_n}, 32'h1);
		pdn <= 1'b1;
		repeat (8) @(posedge sys_clk);
		check({31'h0, pins_oe}, 32'h1);
		oe <= 1'b0;
		repeat (8) @(posedge sys_clk);
		check({31'h0, pins_oe}, 32'h0);
		stop_test();
	end
endmodule
`default_nettype wire
